// ===== core/pqs_pkg.sv
// Purpose: types shared by the quick status block
// Assumes: nothing
// Notes: constants live in pqs_regs.svh
package pqs_pkg;

	typedef enum logic [2:0] {
		PQS_PRE,
		PQS_START,
		PQS_HDR,
		PQS_TA,
		PQS_DATA
	} pqs_fsm_e;

	// 100 Mb/s receive events, one-cycle pulses or levels
	typedef struct packed {
		logic signal_lost;
		logic pll_error;
		logic false_carrier;
		logic invalid_symbol;
		logic halt_symbol;
		logic premature_end;
	} pqs_rx100_s;

	// 10 Mb/s control bits toward the line logic
	typedef struct packed {
		logic jabber_check_inhibit;
		logic auto_polarity_inhibit;
		logic link_force_pass;
		logic squelch_need_idle;
	} pqs_ctl_s;

	typedef struct packed {
		pqs_fsm_e fsm;
		logic [5:0] cnt;
		logic [15:0] sh;
		logic [1:0] op;
		logic match;
		logic [4:0] addr;
		logic mdc_d;
		logic mdio;
		logic mdio_oe_n;
		logic lost;
		logic pll;
		logic fcar;
		logic invs;
		logic halt;
		logic pend;
		logic jab;
		logic rflt;
		logic link;
		logic rjab;
		logic pol;
		logic [13:0] ctl;
		logic rx_err;
		logic tx_d;
		logic [7:0] hb_cnt;
		logic hb;
	} pqs_st_s;

endpackage

// ===== core/pqs_regs.svh
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: management frames carry a 5-bit register address
// Notes: definitions only
`ifndef PQS_REGS_SVH
`define PQS_REGS_SVH

// register addresses
`define PQS_ADDR_QSTAT 5'h11
`define PQS_ADDR_TOPS 5'h12

// quick status fields
`define PQS_QS_LOST 10
`define PQS_QS_PLL 9
`define PQS_QS_FCAR 8
`define PQS_QS_INVS 7
`define PQS_QS_HALT 6
`define PQS_QS_PEND 5
`define PQS_QS_ANC 4
`define PQS_QS_SDET 3
`define PQS_QS_JAB 2
`define PQS_QS_RFLT 1
`define PQS_QS_LINK 0

// operations register fields
`define PQS_TO_RJAB 15
`define PQS_TO_POL 14
`define PQS_TO_JINH 5
`define PQS_TO_APINH 3
`define PQS_TO_HBINH 2
`define PQS_TO_LLINH 1
`define PQS_TO_SQINH 0
`define PQS_TO_RESET 14'h0010

// management frame
`define PQS_PREAMBLE_BITS 6'h20
`define PQS_OP_READ 2'h2
`define PQS_OP_WRITE 2'h1

// timing
`define PQS_CLK_MHZ 125
`define PQS_HB_NS 1000
`define PQS_HB_CYC ((`PQS_HB_NS * `PQS_CLK_MHZ + 999) / 1000)

`endif

// ===== core/pqs_sync.sv
// Purpose: two-flop synchroniser for inputs from outside the clock domain
// Assumes: asynchronous active-low reset already synchronised
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module pqs_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);

	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_q <= '0;
			q_o <= '0;
		end else begin
			meta_q <= d_i;
			q_o <= meta_q;
		end
	end

endmodule
`default_nettype wire

// ===== core/pqs_top.sv
// Purpose: quick status low half and 10 Mb/s operations register
// Assumes: event inputs share clk_i; mdc and mdio arrive from outside
// Notes: registers reached only through the management serial pins
// Functional notes
// - 100 Mb/s signal lost sets sticky bit 10 until read or reset
// - receive PLL lock failure sets sticky bit 9
// - start delimiter not a valid J/K pair sets sticky bit 8
// - erroneous symbol raises receive error and sets sticky bit 7
// - halt code group is signalled to MAC and sets sticky bit 6
// - two consecutive idles inside a packet set sticky bit 5
// - sticky bits show whether their event occurred since last read or reset
// - the six receive error bits only record events at 100 Mb/s
// - bit 4 is one only when negotiation is enabled and finished
// - bit 3 reports live 100 Mb/s signal presence
// - bit 2 is the sticky 10 Mb/s jabber indication
// - bit 1 is the sticky remote fault indication
// - bit 0 is link status, latching low until read
// - operations register decoded at management address 0x12
// - bit 3 set stops automatic receive polarity correction
// - bit 1 set forces 10 Mb/s link integrity into link pass
// - remote jabber sets sticky bit 15, cleared by register read
// - bit 5 set disables jabber checking during transmission
// - heartbeat collision pulse after 10 Mb/s transmit unless bit 2, duplex or repeater
// - bit 0 set requires valid data followed by idle for link
`timescale 1ns/1ps
`default_nettype none
`include "pqs_regs.svh"
module pqs_top
	import pqs_pkg::*;
#(
	parameter logic [4:0] PHY_ADDR = 5'h01,
	parameter int HB_CYCLES = `PQS_HB_CYC
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic mdc_i,
	input wire logic mdio_i,
	output logic mdio_o,
	output logic mdio_oe_n_o,
	input wire logic speed_100_i,
	input wire pqs_rx100_s rx100_i,
	input wire logic an_enable_i,
	input wire logic an_done_i,
	input wire logic signal_detect_i,
	input wire logic jabber_i,
	input wire logic remote_fault_i,
	input wire logic link_ok_i,
	input wire logic remote_jabber_i,
	input wire logic polarity_swapped_i,
	input wire logic full_duplex_i,
	input wire logic repeater_i,
	input wire logic tx_en_i,
	output logic rx_error_o,
	output logic collision_heartbeat_test_o,
	output pqs_ctl_s ctl_o
);

	logic [1:0] rst_q;
	logic rst_n;
	logic mdc_s;
	logic mdio_s;
	logic mdc_rise;
	logic rd17;
	logic rd18;
	logic wr18;
	logic hb_trig;
	logic [11:0] hdr;
	logic [15:0] wdata;
	logic [15:0] qs_word;
	logic [15:0] to_word;
	logic [15:0] rdata;
	pqs_st_s s;
	pqs_st_s n;

	// reset release through two flops
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_q <= 2'h0;
		end else begin
			rst_q <= {rst_q[0], 1'b1};
		end
	end
	assign rst_n = rst_q[1];

	pqs_sync #(
		.WIDTH(2)
	) u_sync (
		.clk_i(clk_i),
		.rst_n_i(rst_n),
		.d_i({mdc_i, mdio_i}),
		.q_o({mdc_s, mdio_s})
	);

	assign mdc_rise = mdc_s & ~s.mdc_d;
	assign hdr = {s.sh[10:0], mdio_s};
	assign wdata = {s.sh[14:0], mdio_s};

	always_comb begin
		qs_word = 16'h0000;
		qs_word[`PQS_QS_LOST] = s.lost;
		qs_word[`PQS_QS_PLL] = s.pll;
		qs_word[`PQS_QS_FCAR] = s.fcar;
		qs_word[`PQS_QS_INVS] = s.invs;
		qs_word[`PQS_QS_HALT] = s.halt;
		qs_word[`PQS_QS_PEND] = s.pend;
		qs_word[`PQS_QS_ANC] = an_enable_i & an_done_i;
		qs_word[`PQS_QS_SDET] = signal_detect_i;
		qs_word[`PQS_QS_JAB] = s.jab;
		qs_word[`PQS_QS_RFLT] = s.rflt;
		qs_word[`PQS_QS_LINK] = s.link;
		to_word = {s.rjab, s.pol, s.ctl};
		case (hdr[4:0])
			`PQS_ADDR_QSTAT: begin
				rdata = qs_word;
			end
			`PQS_ADDR_TOPS: begin
				rdata = to_word;
			end
			default: begin
				rdata = 16'h0000;
			end
		endcase
	end

	always_comb begin
		n = s;
		rd17 = 1'b0;
		rd18 = 1'b0;
		wr18 = 1'b0;
		n.mdc_d = mdc_s;
		// management frame engine, one step per mdc rising edge
		if (mdc_rise) begin
			case (s.fsm)
				PQS_PRE: begin
					if (mdio_s) begin
						if (s.cnt != `PQS_PREAMBLE_BITS) begin
							n.cnt = s.cnt + 6'h01;
						end
					end else begin
						if (s.cnt == `PQS_PREAMBLE_BITS) begin
							n.fsm = PQS_START;
						end
						n.cnt = 6'h00;
					end
				end
				PQS_START: begin
					n.fsm = mdio_s ? PQS_HDR : PQS_PRE;
					n.cnt = 6'h00;
				end
				PQS_HDR: begin
					n.sh = {s.sh[14:0], mdio_s};
					n.cnt = s.cnt + 6'h01;
					if (s.cnt == 6'h0B) begin
						n.op = hdr[11:10];
						n.match = (hdr[9:5] == PHY_ADDR);
						n.addr = hdr[4:0];
						n.cnt = 6'h00;
						n.fsm = PQS_TA;
						if (hdr[11:10] == `PQS_OP_READ && hdr[9:5] == PHY_ADDR) begin
							n.sh = rdata;
							rd17 = (hdr[4:0] == `PQS_ADDR_QSTAT);
							rd18 = (hdr[4:0] == `PQS_ADDR_TOPS);
						end
					end
				end
				PQS_TA: begin
					n.cnt = s.cnt + 6'h01;
					if (s.op == `PQS_OP_READ && s.match) begin
						n.mdio_oe_n = 1'b0;
						n.mdio = (s.cnt == 6'h00) ? 1'b0 : s.sh[15];
					end
					if (s.cnt == 6'h01) begin
						n.fsm = PQS_DATA;
						n.cnt = 6'h00;
					end
				end
				PQS_DATA: begin
					n.cnt = s.cnt + 6'h01;
					if (s.op == `PQS_OP_READ) begin
						n.sh = {s.sh[14:0], 1'b0};
						n.mdio = s.sh[14];
					end else begin
						n.sh = wdata;
					end
					if (s.cnt == 6'h0F) begin
						n.fsm = PQS_PRE;
						n.cnt = 6'h00;
						n.mdio = 1'b1;
						n.mdio_oe_n = 1'b1;
						wr18 = (s.op == `PQS_OP_WRITE) && s.match &&
							(s.addr == `PQS_ADDR_TOPS);
					end
				end
				default: begin
					n.fsm = PQS_PRE;
					n.cnt = 6'h00;
					n.mdio_oe_n = 1'b1;
				end
			endcase
		end
		// reserved bits stored as written; software keeps defaults
		if (wr18) begin
			n.ctl = wdata[13:0];
		end
		// sticky flags: a set in the clearing cycle wins
		n.lost = (speed_100_i & rx100_i.signal_lost) | (s.lost & ~rd17);
		n.pll = (speed_100_i & rx100_i.pll_error) | (s.pll & ~rd17);
		n.fcar = (speed_100_i & rx100_i.false_carrier) | (s.fcar & ~rd17);
		n.invs = (speed_100_i & rx100_i.invalid_symbol) | (s.invs & ~rd17);
		n.halt = (speed_100_i & rx100_i.halt_symbol) | (s.halt & ~rd17);
		n.pend = (speed_100_i & rx100_i.premature_end) | (s.pend & ~rd17);
		n.jab = jabber_i | (s.jab & ~rd17);
		n.rflt = remote_fault_i | (s.rflt & ~rd17);
		n.link = rd17 ? link_ok_i : (s.link & link_ok_i);
		n.rjab = remote_jabber_i | (s.rjab & ~rd18);
		n.pol = polarity_swapped_i | (s.pol & ~rd18);
		// receive error toward the MAC for bad or halt symbols
		n.rx_err = speed_100_i & (rx100_i.invalid_symbol | rx100_i.halt_symbol);
		// heartbeat after each 10 Mb/s transmission unless bit 2, full duplex or repeater
		n.tx_d = tx_en_i;
		if (hb_trig) begin
			n.hb_cnt = HB_CYCLES[7:0];
		end else if (s.hb_cnt != 8'h00) begin
			n.hb_cnt = s.hb_cnt - 8'h01;
		end
		n.hb = (n.hb_cnt != 8'h00);
	end

	assign hb_trig = s.tx_d & ~tx_en_i & ~speed_100_i & ~s.ctl[`PQS_TO_HBINH] &
		~full_duplex_i & ~repeater_i;

	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
			s.fsm <= PQS_PRE;
			s.mdio <= 1'b1;
			s.mdio_oe_n <= 1'b1;
			s.ctl <= `PQS_TO_RESET;
		end else begin
			s <= n;
		end
	end

	assign mdio_o = s.mdio;
	assign mdio_oe_n_o = s.mdio_oe_n;
	assign rx_error_o = s.rx_err;
	assign collision_heartbeat_test_o = s.hb;
	assign ctl_o.jabber_check_inhibit = s.ctl[`PQS_TO_JINH];
	assign ctl_o.auto_polarity_inhibit = s.ctl[`PQS_TO_APINH];
	assign ctl_o.link_force_pass = s.ctl[`PQS_TO_LLINH];
	assign ctl_o.squelch_need_idle = s.ctl[`PQS_TO_SQINH];

	// checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n);

	a_lost_sets: assert property (speed_100_i && rx100_i.signal_lost
		|=> qs_word[`PQS_QS_LOST]) else $error("signal lost flag not set");
	a_sticky_holds: assert property (s.pll && !rd17 |=> s.pll [*1])
		else $error("pll flag dropped without read");
	a_read_clears: assert property (rd17 && !rx100_i.halt_symbol |=> !s.halt)
		else $error("halt flag not cleared by read");
	a_rxer_follows: assert property (speed_100_i && rx100_i.invalid_symbol
		|=> rx_error_o && s.invs) else $error("receive error not raised");
	a_link_drops: assert property (!link_ok_i && !rd17 |=> !s.link)
		else $error("link status not latched low");
	a_rjab_clear: assert property (rd18 && !remote_jabber_i |=> !s.rjab)
		else $error("remote jabber not cleared");
	a_ctl_write: assert property (wr18 |=> s.ctl == $past(wdata[13:0]))
		else $error("operations write lost");
	a_hb_pulse: assert property (hb_trig |=> collision_heartbeat_test_o [*8])
		else $error("heartbeat pulse too short");
	a_hb_inhibit: assert property (s.ctl[`PQS_TO_HBINH] && s.hb_cnt == 8'h00
		|=> !collision_heartbeat_test_o) else $error("heartbeat not inhibited");
	a_ta_zero: assert property ($fell(mdio_oe_n_o) |-> !mdio_o)
		else $error("turnaround bit not zero");
	a_idle_release: assert property (s.fsm inside {PQS_PRE, PQS_START, PQS_HDR}
		|-> mdio_oe_n_o) else $error("mdio driven outside read data");
	a_rxer_halt: assert property (speed_100_i && rx100_i.halt_symbol
		|=> rx_error_o && s.halt) else $error("halt not signalled");
	a_fcar_sets: assert property (speed_100_i && rx100_i.false_carrier
		|=> s.fcar) else $error("false carrier flag not set");
	a_pend_sets: assert property (speed_100_i && rx100_i.premature_end
		|=> s.pend) else $error("premature end flag not set");
	a_slow_hold: assert property (!speed_100_i && !rd17 && !s.invs
		|=> !s.invs) else $error("symbol flag set at 10 Mb/s");
	a_jab_sets: assert property (jabber_i |=> s.jab)
		else $error("jabber flag not set");
	a_rflt_sets: assert property (remote_fault_i |=> s.rflt)
		else $error("remote fault flag not set");
	a_pol_sets: assert property (polarity_swapped_i |=> s.pol)
		else $error("polarity flag not set");
	a_hb_suppress: assert property ((full_duplex_i || repeater_i) &&
		s.hb_cnt == 8'h00 |=> !collision_heartbeat_test_o)
		else $error("heartbeat not suppressed");

	c_read_qs: cover property (rd17 ##[1:300] s.fsm == PQS_DATA);
	c_write_ops: cover property (wr18);
	c_heartbeat: cover property (hb_trig ##1 collision_heartbeat_test_o);
	c_rx_error: cover property (rx_error_o);
	c_rjab_read: cover property (rd18 && s.rjab);

endmodule
`default_nettype wire

// ===== dv/pqs_sta.sv
// Purpose: station management model driving the serial pins
// Assumes: the data line is pulled up when nobody drives it
// Notes: mdc stands still low between frames
`timescale 1ns/1ps
`default_nettype none
module pqs_sta (
	output logic mdc_o,
	output logic drv_o,
	output logic dat_o,
	input wire logic line_i
);
	initial begin
		mdc_o = 1'b0;
		drv_o = 1'b0;
		dat_o = 1'b1;
	end
	task automatic bit_out(input logic b);
		drv_o = 1'b1;
		dat_o = b;
		#32 mdc_o = 1'b1;
		#32 mdc_o = 1'b0;
	endtask
	// one whole frame with its own preamble; rd[16] is the second ta bit
	task automatic frame(input logic [1:0] op, input logic [4:0] pa,
		input logic [4:0] ra, input logic [15:0] wd,
		output logic [16:0] rd);
		logic [45:0] hdr;
		#3;
		rd = '1;
		hdr = {32'hFFFFFFFF, 2'h1, op, pa, ra};
		if (op == 2'h1 && ra == 5'h12) begin
			wd[13:6] = 8'h00;
			wd[4] = 1'b1;
		end
		for (int i = 45; i >= 0; i--) bit_out(hdr[i]);
		if (op == 2'h1) begin
			bit_out(1'b1);
			bit_out(1'b0);
			for (int i = 15; i >= 0; i--) bit_out(wd[i]);
		end else begin
			drv_o = 1'b0;
			for (int i = 17; i >= 0; i--) begin
				#32 mdc_o = 1'b1;
				if (i < 17) rd[i] = line_i;
				#32 mdc_o = 1'b0;
			end
		end
		drv_o = 1'b0;
		dat_o = 1'b1;
	endtask
endmodule
`default_nettype wire

// ===== dv/pqs_top_tb.sv
// Purpose: self-checking bench for the quick status block
// Assumes: management frames come from the station model
// Notes: heartbeat shortened to 10 cycles
`timescale 1ns/1ps
`default_nettype none
module pqs_top_tb;
	import pqs_pkg::*;
	localparam int HB = 10;
	logic clk_i, rst_n_i, mdc, drv, dat, mdio_o, oe_n, line, rxe, hb;
	logic speed, an_en, an_dn, sdet, jab, rflt, lnk, rj, pol, fdx, rep, tx;
	logic sj, sr, sl, srj, sp;
	logic [5:0] sf;
	logic [13:0] ctlw;
	logic [16:0] rd;
	logic [31:0] r;
	pqs_rx100_s rx;
	pqs_ctl_s ctl;
	int n_mismatch, samples_checked, n;
	assign line = !oe_n ? mdio_o : (drv ? dat : 1'b1);
	pqs_top #(.HB_CYCLES(HB)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.mdc_i(mdc), .mdio_i(line), .mdio_o(mdio_o), .mdio_oe_n_o(oe_n),
		.speed_100_i(speed), .rx100_i(rx), .an_enable_i(an_en),
		.an_done_i(an_dn), .signal_detect_i(sdet), .jabber_i(jab),
		.remote_fault_i(rflt), .link_ok_i(lnk), .remote_jabber_i(rj),
		.polarity_swapped_i(pol), .full_duplex_i(fdx), .repeater_i(rep),
		.tx_en_i(tx), .rx_error_o(rxe), .collision_heartbeat_test_o(hb),
		.ctl_o(ctl));
	pqs_sta sta (.mdc_o(mdc), .drv_o(drv), .dat_o(dat), .line_i(line));
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		samples_checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic rdreg(input logic [4:0] ra, input logic [4:0] pa);
		logic [15:0] e;
		logic hit;
		hit = pa == 5'h01;
		e = !hit ? 16'hFFFF : ra == 5'h11 ?
			{5'h00, sf, an_en & an_dn, sdet, sj, sr, sl} :
			ra == 5'h12 ? {srj, sp, ctlw} : 16'h0000;
		sta.frame(2'h2, pa, ra, 16'h0000, rd);
		chk(rd[15:0], e);
		chk({15'h0000, rd[16]}, {15'h0000, !hit});
		if (hit && ra == 5'h11) begin
			sf = 6'h00;
			sj = jab;
			sr = rflt;
			sl = lnk;
		end
		if (hit && ra == 5'h12) begin
			srj = rj;
			sp = pol;
		end
		for (int i = 0; i <= 16; i++) begin
			@(negedge clk_i);
			if (oe_n === 1'b1) break;
			if (i == 16) begin
				n_mismatch++;
				tally_and_finish();
			end
		end
	endtask
	task automatic wrreg(input logic [15:0] w);
		sta.frame(2'h1, 5'h01, 5'h12, w, rd);
		ctlw = {8'h00, w[5], 1'b1, w[3:0]};
		repeat (8) @(negedge clk_i);
		chk({12'h000, ctl}, {12'h000, ctlw[5], ctlw[3], ctlw[1], ctlw[0]});
	endtask
	initial begin
		rst_n_i = 1'b0;
		{speed, an_en, an_dn, sdet, jab, rflt, lnk, rj, pol, fdx, rep} = '0;
		{tx, sj, sr, sl, srj, sp} = '0;
		rx = '0;
		sf = 6'h00;
		ctlw = 14'h0010;
		n_mismatch = 0;
		samples_checked = 0;
		void'($urandom(29));
		repeat (12) @(negedge clk_i);
		rst_n_i = 1'b1;
		repeat (8) @(negedge clk_i);
		chk({12'h000, ctl}, 16'h0000);
		rdreg(5'h12, 5'h01);
		rdreg(5'h11, 5'h01);
		$display("test reset done");
		speed = 1'b1;
		for (int i = 0; i < 6; i++) begin
			rx = pqs_rx100_s'(6'h20 >> i);
			sf = sf | rx;
			@(negedge clk_i);
			rx = '0;
			chk({15'h0000, rxe}, {15'h0000, i == 3 || i == 4});
			rdreg(5'h11, 5'h01);
			rdreg(5'h11, 5'h01);
		end
		speed = 1'b0;
		rx = pqs_rx100_s'(6'h3F);
		@(negedge clk_i);
		rx = '0;
		chk({15'h0000, rxe}, 16'h0000);
		rdreg(5'h11, 5'h01);
		$display("test sticky done");
		repeat (12) begin
			r = $urandom;
			{an_en, an_dn, sdet, jab, rflt, lnk, rj, pol} = r[7:0];
			sj = sj | jab;
			sr = sr | rflt;
			sl = sl & lnk;
			srj = srj | rj;
			sp = sp | pol;
			wrreg(r[31:16]);
			rdreg(5'h11, 5'h01);
			rdreg(5'h12, 5'h01);
			rdreg(5'h13, 5'h01);
			rdreg(5'h12, 5'h02);
		end
		$display("test random done");
		for (int k = 0; k < 8; k++) begin
			{fdx, rep} = k[1:0];
			wrreg({13'h0000, k[2], 2'h0});
			tx = 1'b1;
			repeat (3) @(negedge clk_i);
			tx = 1'b0;
			n = 0;
			for (int c = 0; c < 3 * HB; c++) begin
				@(negedge clk_i);
				if (hb === 1'b1) n++;
			end
			chk(16'(n), k == 0 ? 16'(HB) : 16'h0000);
		end
		$display("test heartbeat done");
		tally_and_finish();
	end
endmodule
`default_nettype wire
